// File: logic/ccs_clock_mux.v
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Glitch-free two-input clock multiplexer
// ------------------------------------------------------------
// Each source has its own two-stage enable chain clocked on its
// falling edge, so a source is released only after the other is
// quiet and switching never cuts a pulse short.
module ccs_clock_mux (
    // Clock sources and reset
    input  wire clkMain,
    input  wire clkFast,
    input  wire rst_n,
    // Selection
    input  wire selFast,
    // Output
    output wire clkCpu,
    output wire fastActive
);

    reg mainSync1;
    reg mainSync2;
    reg fastSync1;
    reg fastSync2;

    always @(negedge clkMain or negedge rst_n) begin
        if (!rst_n) begin
            mainSync1 <= 1'b1;
            mainSync2 <= 1'b1;
        end else begin
            mainSync1 <= ~selFast & ~fastSync2;
            mainSync2 <= mainSync1;
        end
    end

    always @(negedge clkFast or negedge rst_n) begin
        if (!rst_n) begin
            fastSync1 <= 1'b0;
            fastSync2 <= 1'b0;
        end else begin
            fastSync1 <= selFast & ~mainSync2;
            fastSync2 <= fastSync1;
        end
    end

    assign clkCpu     = (clkMain & mainSync2) | (clkFast & fastSync2); // R14
    assign fastActive = fastSync2;

endmodule

`default_nettype wire

// File: logic/ccs_clock_switch.v
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1 - Bit 3 selects fast or main clock
// R2 - Bit 2 starts or stops fast oscillator
// R3 - Crystal option: bit 0 picks supply level
// R4 - RC option: supply fixed at high level
// R5 - Low voltage and oscillator off blocks switch
// R6 - RC option: low voltage never blocks switch
// R7 - Reset clears all three control bits
// R8 - Bit 1 reads zero, ignores writes
// R9 - Software raises voltage, waits before enabling
// R10 - Software waits after enabling before selecting
// R11 - Return order: select, enable, then voltage
// R12 - Clear select and enable separately
// R13 - Instruction time follows selected clock rate
// R14 - Clock changes produce no runt pulses

`include "ccs_defs.vh"

module ccs_clock_switch #(
    parameter RC_MAIN_OSC = 0
) (
    // System
    input  wire        clk,
    input  wire        rst_n,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Oscillator clocks
    input  wire        main_oscillator,
    input  wire        fast_sub_oscillator,
    // Controls to the analog side
    output wire        fastOscEnable,
    output wire        coreSupplyLevel,
    // CPU clock
    output wire        cpuClock,
    output wire        cpuClockIsFast,
    output reg  [31:0] instrTimeNs
);

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    reg cpu_clock_select;
    reg fast_osc_enable;
    reg core_voltage_select;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    reg        wrPending;
    wire       addrHit;
    wire       phaseValid;

    assign phaseValid = hsel & hready & htrans[1];
    assign addrHit    = (haddr == `CCS_ADDR_OSC_CTRL);
    assign hreadyout  = 1'b1;
    assign hresp      = `CCS_HRESP_OKAY;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPending <= 1'b0;
        end else begin
            wrPending <= phaseValid & hwrite & addrHit;
        end
    end

    // A set of the select bit is refused while the fast clock could
    // not run: supply low and oscillator stopped.
    function selectAllowed;
        input voltSel;
        input oscEn;
        input rcOpt;
        begin
            selectAllowed = rcOpt | voltSel | oscEn; // R5 R6
        end
    endfunction

    wire wrSel  = hwdata[`CCS_BIT_CLK_SEL];
    wire wrOsc  = hwdata[`CCS_BIT_OSC_EN];
    wire wrVolt = hwdata[`CCS_BIT_VOLT_SEL];
    wire rcOpt  = (RC_MAIN_OSC != 0);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clock_select    <= `CCS_CTRL_RESET; // R7
            fast_osc_enable     <= `CCS_CTRL_RESET; // R7
            core_voltage_select <= `CCS_CTRL_RESET; // R7
        end else if (wrPending) begin
            fast_osc_enable     <= wrOsc; // R2
            core_voltage_select <= wrVolt;
            // The check uses the stored bits, so on the crystal option a single write that
            // raises voltage and sets select while the oscillator is stopped is still refused.
            if (!wrSel) begin
                cpu_clock_select <= 1'b0; // R1
            end else if (selectAllowed(core_voltage_select,
                                       fast_osc_enable, rcOpt)) begin
                cpu_clock_select <= 1'b1; // R1 R5
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (phaseValid & ~hwrite) begin
            hrdata <= 32'h00000000;
            if (addrHit) begin
                hrdata[`CCS_BIT_CLK_SEL]  <= cpu_clock_select;
                hrdata[`CCS_BIT_OSC_EN]   <= fast_osc_enable;
                hrdata[`CCS_BIT_UNUSED]   <= 1'b0; // R8
                hrdata[`CCS_BIT_VOLT_SEL] <= core_voltage_select;
            end
        end
    end

    // ------------------------------------------------------------
    // Analog controls and clock selection
    // ------------------------------------------------------------
    assign fastOscEnable   = fast_osc_enable; // R2
    assign coreSupplyLevel = rcOpt ? 1'b1 : core_voltage_select; // R3 R4

    ccs_clock_mux uMux (
        .clkMain    (main_oscillator),
        .clkFast    (fast_sub_oscillator),
        .rst_n      (rst_n),
        .selFast    (cpu_clock_select),
        .clkCpu     (cpuClock),
        .fastActive (cpuClockIsFast)
    ); // R14

    // Instruction time reported from the selected source.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instrTimeNs <= `CCS_INSTR_NS_XTAL;
        end else if (cpu_clock_select) begin
            instrTimeNs <= `CCS_INSTR_NS_FAST; // R13
        end else if (rcOpt) begin
            instrTimeNs <= `CCS_INSTR_NS_RC; // R13
        end else begin
            instrTimeNs <= `CCS_INSTR_NS_XTAL; // R13
        end
    end

endmodule

`default_nettype wire

// File: logic/ccs_defs.vh
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

// Register byte offset of the oscillator and clock control word.
`define CCS_ADDR_OSC_CTRL   32'h0000FF00
// Field positions inside the control word.
`define CCS_BIT_VOLT_SEL    0
`define CCS_BIT_UNUSED      1
`define CCS_BIT_OSC_EN      2
`define CCS_BIT_CLK_SEL     3
// Reset value of the control fields.
`define CCS_CTRL_RESET      1'b0
// Bus encodings.
`define CCS_HTRANS_NONSEQ   2'h2
`define CCS_HTRANS_SEQ      2'h3
`define CCS_HRESP_OKAY      1'b0
// Instruction timing in nanoseconds per one-cycle instruction.
`define CCS_INSTR_NS_XTAL   32'h0000EE48
`define CCS_INSTR_NS_RC     32'h000080E8
`define CCS_INSTR_NS_FAST   32'h000001F4

`endif

// File: tb/ccs_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"
module ccs_checker #(
    parameter RC_MAIN_OSC = 0
) (
    input wire logic        clk, rst_n, hsel, hwrite, hready,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic        fastOscEnable, coreSupplyLevel, cpuClockIsFast
);
    // A write takes effect at the end of its data phase, one cycle late.
    wire  hit = hsel && hready && htrans[1] && haddr == `CCS_ADDR_OSC_CTRL;
    wire  rdA = hit && !hwrite;
    logic wp;
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            wp <= 1'b0;
        else
            wp <= hit && hwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_osc_follow: assert property
        (wp |=> fastOscEnable == $past(hwdata[2])) else $error("Enable.");
    a_supply_set: assert property
        (wp |=> coreSupplyLevel == (RC_MAIN_OSC != 0 || $past(hwdata[0])))
        else $error("Supply level.");
    a_supply_hold: assert property
        (!wp |=> $stable(coreSupplyLevel)) else $error("Supply moved.");
    a_read_zero: assert property
        (rdA |=> hrdata[31:4] == 0 && !hrdata[1]) else $error("Read bits.");
    a_read_back: assert property
        (rdA |=> hrdata[2] == $past(fastOscEnable)) else $error("Readback.");
    a_refuse_fast: assert property
        (RC_MAIN_OSC == 0 && wp && hwdata[3] && !coreSupplyLevel
         && !fastOscEnable && !cpuClockIsFast
         |=> !cpuClockIsFast [*8] ##20 !cpuClockIsFast)
        else $error("Switch not refused.");
    a_sel_fast: assert property
        (wp && hwdata[3] && (coreSupplyLevel || fastOscEnable)
         |-> ##[1:30] cpuClockIsFast) else $error("No fast clock.");
    a_main_back: assert property
        (wp && !hwdata[3] |-> ##[1:30] !cpuClockIsFast) else $error("Main.");
    cover property (wp && hwdata[3]);
    cover property (cpuClockIsFast);
    cover property (rdA);
endmodule
bind ccs_clock_switch ccs_checker #(.RC_MAIN_OSC(RC_MAIN_OSC)) mon (
    .clk, .rst_n, .hsel, .hwrite, .hready, .htrans, .haddr, .hwdata,
    .hrdata, .fastOscEnable, .coreSupplyLevel, .cpuClockIsFast);
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"
module testbench;
    localparam logic [31:0] ctrlAddr = `CCS_ADDR_OSC_CTRL;
    logic        clk, rst_n, hwrite, mainOsc, fastOsc;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, rd, e;
    wire         hrdy, oscEn, supply, isFast, cpuClk, hresp;
    wire  [31:0] hrdata, instrNs;
    int          errors, n_checks;
    // Value written in the upper nibble, settled control word below it.
    logic [7:0]  rows [9] = '{8'h11, 8'h55, 8'hDD, 8'h55, 8'h11, 8'h00,
                              8'hA0, 8'h91, 8'h00};
    ccs_clock_switch #(.RC_MAIN_OSC(0)) dut (.clk(clk), .rst_n(rst_n),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
        .hresp(hresp), .hrdata(hrdata), .main_oscillator(mainOsc),
        .fast_sub_oscillator(fastOsc), .fastOscEnable(oscEn),
        .coreSupplyLevel(supply), .cpuClock(cpuClk), .cpuClockIsFast(isFast),
        .instrTimeNs(instrNs));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always #20 mainOsc = ~mainOsc;
    // Both sources toggle on even times only, so the muxed clock is
    // settled at every odd-timed rising edge of clk where it is compared.
    always #4 fastOsc = ~fastOsc;
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1) begin
            errors++;
            give_verdict();
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        haddr <= a;
        hwrite <= w;
        htrans <= `CCS_HTRANS_NONSEQ;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask
    initial begin
        {rst_n, hwrite, htrans, haddr, hwdata, mainOsc, fastOsc} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        ahb(1'b0, ctrlAddr, 32'h0);
        chk(rd, 32'h0);
        chk({hresp, isFast, oscEn, supply}, 32'h0);
        chk(cpuClk, mainOsc);
        chk(instrNs, `CCS_INSTR_NS_XTAL);
        foreach (rows[i]) begin
            e = {28'h0, rows[i][3:0]};
            ahb(1'b1, ctrlAddr, {28'h0, rows[i][7:4]});
            repeat (40) @(posedge clk);
            ahb(1'b0, ctrlAddr, 32'h0);
            chk(rd, e);
            chk({isFast, oscEn, 1'b0, supply}, e);
            chk(instrNs, e[3] ? `CCS_INSTR_NS_FAST : `CCS_INSTR_NS_XTAL);
            chk(cpuClk, e[3] ? fastOsc : mainOsc);
        end
        ahb(1'b1, ctrlAddr, 32'h5);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        chk({hresp, isFast, oscEn, supply}, 32'h0);
        ahb(1'b1, 32'h0000FF04, 32'hF);
        ahb(1'b0, 32'h0000FF04, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, ctrlAddr, 32'h0);
        chk(rd, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
